//--- ddrc_core.sv
// dram command decode, mode registers, bank state and read burst engine
// Function
// R01: mrs loads bank-selected mode register from address
// R02: controller issues mrs only when all idle
// R03: controller waits mrd and mod after mrs
// R04: zq commands only with banks precharged
// R05: channel quiet during calibration except zq
// R06: zq may overlap dll lock; explicit after
// R07: shared zq resistor: ranks never overlap calibration
// R08: cke high, odt off, bus hi-z
// R09: column command only to activated bank
// R10: early column command accepted with additive latency
// R11: controller rounds time limits up to clocks
// R12: same-type column commands spaced by ccd
// R13: same bank reactivate after precharge, rc
// R14: rrd spacing, max four activates per faw
// R15: first data rl clocks later, then each crossing
// R16: strobe preamble, postamble, then release lines; code releases the strobe right after the last data, with no postamble
// R17: a10 selects auto precharge after read burst
// R18: ccd reads gapless bl8, gap bc4, uninterrupted
// R19: read to write spacing by controller
// R20: explicit precharge spacing after read by controller
// R21: auto precharge waits al+rtp and ras lockout
// R22: ap never within four clocks of prefetch
// R23: commands decoded from strobe pins on ck
`include "ddrc_defs.svh"
module ddrc_core (
  // system side
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // link clock and command pins
  input  wire logic                    ck_cmd,
  input  wire ddrc_pkg::ddrc_cmd_pins_t cmd,
  // data pins, two elements per ck cycle, rising element in the high byte
  input  wire logic [15:0]             dq_i,
  output logic      [15:0]             dq_o,
  output logic                         dq_oe,
  // strobe pins, rising half in bit 1
  input  wire logic [1:0]              dqs_i,
  output logic      [1:0]              dqs_o,
  output logic      [1:0]              dqs_c_o,
  output logic                         dqs_oe,
  // status on ref_clk
  output logic      [7:0]              stat_banks_open,
  output logic                         stat_cal_busy,
  output logic                         stat_mrs_pulse
);
  import ddrc_pkg::*;
  function automatic ddrc_cmd_t decode_cmd(input ddrc_cmd_pins_t p);
    if (p.cs_n) begin
      decode_cmd = DDRC_C_DES;
    end else begin
      decode_cmd = ddrc_cmd_t'({1'b0, p.ras_n, p.cas_n, p.we_n}); // [R23]
    end
  endfunction : decode_cmd
  function automatic logic [7:0] elem_byte(input logic [9:0] c, input logic [2:0] e);
    elem_byte = {c[7:3], 3'(c[2:0] + e)};
  endfunction : elem_byte
  // reset release per domain; ck may stop, so its copy only needs edges during traffic
  logic       rrst_s1_ff;
  logic       rrst_ff;
  logic       crst_s1_ff;
  logic       crst_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rrst_s1_ff <= 1'b0;
      rrst_ff    <= 1'b0;
    end else begin
      rrst_s1_ff <= 1'b1;
      rrst_ff    <= rrst_s1_ff;
    end
  end
  always_ff @(posedge ck_cmd or negedge rst_n) begin
    if (!rst_n) begin
      crst_s1_ff <= 1'b0;
      crst_ff    <= 1'b0;
    end else begin
      crst_s1_ff <= 1'b1;
      crst_ff    <= crst_s1_ff;
    end
  end
  // link-side state
  logic [13:0]  mr_ff     [4];
  logic [13:0]  nxt_mr    [4];
  ddrc_bank_t   bank_ff   [8];
  ddrc_bank_t   nxt_bank  [8];
  ddrc_rd_evt_t pipe_ff   [`DDRC_PIPE_DEPTH];
  ddrc_rd_evt_t nxt_pipe  [`DDRC_PIPE_DEPTH];
  ddrc_rdst_t   rs_ff;
  ddrc_rdst_t   nxt_rs;
  logic [2:0]   left_ff;
  logic [2:0]   nxt_left;
  logic [2:0]   elem_ff;
  logic [2:0]   nxt_elem;
  logic [9:0]   col_ff;
  logic [9:0]   nxt_col;
  logic [9:0]   cal_ff;
  logic [9:0]   nxt_cal;
  logic         mrs_tgl_ff;
  logic         nxt_mrs_tgl;
  logic [7:0]   open_ff;
  logic [7:0]   nxt_open;
  logic [15:0]  nxt_dq;
  logic         nxt_dq_oe;
  logic [1:0]   nxt_dqs;
  logic         nxt_dqs_oe;
  ddrc_cmd_t    cur;
  logic [4:0]   cl;
  logic [4:0]   al;
  logic [4:0]   rl;
  logic         bc4;
  logic         start;
  logic         prep;
  logic         data_now;
  logic [2:0]   e;
  logic [9:0]   c;
  always_comb begin
    cur         = decode_cmd(cmd);
    cl          = 5'(`DDRC_CL_BASE + {2'h0, mr_ff[0][`DDRC_MR0_CL_LSB +: 3]});
    case (mr_ff[1][`DDRC_MR1_AL_LSB +: 2])
      2'h1:    al = 5'(cl - 5'h01);
      2'h2:    al = 5'(cl - 5'h02);
      default: al = 5'h00;
    endcase
    rl          = 5'(al + cl); // [R15]
    // fixed bc4, or on-the-fly with the chop bit low
    case (mr_ff[0][`DDRC_MR0_BL_LSB +: 2])
      2'h1:    bc4 = ~cmd.addr[`DDRC_BC_BIT];
      2'h2:    bc4 = 1'b1;
      default: bc4 = 1'b0;
    endcase
    nxt_mr      = mr_ff;
    nxt_bank    = bank_ff;
    nxt_mrs_tgl = mrs_tgl_ff;
    nxt_cal     = (cal_ff != 10'h000) ? 10'(cal_ff - 10'h001) : 10'h000;
    // read events walk one stage per clock
    nxt_pipe[0] = '0;
    for (int i = 1; i < `DDRC_PIPE_DEPTH; i++) begin
      nxt_pipe[i] = pipe_ff[i-1];
    end
    for (int i = 0; i < 8; i++) begin
      if (bank_ff[i].open && (bank_ff[i].ras_cnt != 6'h3f)) begin
        nxt_bank[i].ras_cnt = 6'(bank_ff[i].ras_cnt + 6'h01);
      end
      if (bank_ff[i].ap_pend) begin
        if (bank_ff[i].ap_cnt != 6'h00) begin
          nxt_bank[i].ap_cnt = 6'(bank_ff[i].ap_cnt - 6'h01);
        end else if (bank_ff[i].ras_cnt >= 6'(`DDRC_RAS_CYC - 1)) begin // [R21]
          nxt_bank[i].open    = 1'b0;
          nxt_bank[i].ap_pend = 1'b0;
        end
      end
    end
    case (cur)
      DDRC_C_MRS: begin
        if (!cmd.ba[2]) begin
          nxt_mr[cmd.ba[1:0]] = cmd.addr; // [R01]
          nxt_mrs_tgl         = ~mrs_tgl_ff;
        end
      end
      DDRC_C_ACT: begin
        nxt_bank[cmd.ba].open    = 1'b1;
        nxt_bank[cmd.ba].ap_pend = 1'b0;
        nxt_bank[cmd.ba].ras_cnt = 6'h00;
      end
      DDRC_C_PRE: begin
        for (int i = 0; i < 8; i++) begin
          if (cmd.addr[`DDRC_AP_BIT] || (cmd.ba == 3'(i))) begin
            nxt_bank[i].open    = 1'b0;
            nxt_bank[i].ap_pend = 1'b0;
          end
        end
      end
      DDRC_C_RD: begin
        // no row-to-column check: an early read leans on posted latency
        nxt_pipe[0] = '{vld: 1'b1, bc4: bc4, col: cmd.addr[9:0]}; // [R10]
        if (cmd.addr[`DDRC_AP_BIT]) begin
          nxt_bank[cmd.ba].ap_pend = 1'b1; // [R17]
          // rtp is at least four clocks, so the last prefetch is always cleared
          nxt_bank[cmd.ba].ap_cnt  = 6'(6'(al) + 6'(`DDRC_RTP_CYC - 1)); // [R21] [R22]
        end
      end
      DDRC_C_ZQ: begin
        // a further zq simply restarts the interval
        nxt_cal = cmd.addr[`DDRC_AP_BIT] ? `DDRC_ZQCL_CYC : `DDRC_ZQCS_CYC; // [R05]
      end
      default: begin
      end
    endcase
    for (int i = 0; i < 8; i++) begin
      nxt_open[i] = nxt_bank[i].open;
    end
    // burst engine; with ccd spacing a new start lands just as an old bl8 burst ends; a bc4 leaves a gap
    start      = pipe_ff[5'(rl - 5'h01)].vld; // [R15]
    prep       = pipe_ff[5'(rl - 5'h02)].vld;
    data_now   = start || ((rs_ff == DDRC_RS_DATA) && (left_ff != 3'h0)); // [R18]
    e          = start ? 3'h0 : 3'(elem_ff + 3'h2);
    c          = start ? pipe_ff[5'(rl - 5'h01)].col : col_ff;
    nxt_elem   = e;
    nxt_col    = c;
    nxt_dq     = 16'h0000;
    nxt_dq_oe  = 1'b0;
    nxt_dqs    = 2'h0;
    nxt_dqs_oe = 1'b0;
    if (start) begin
      nxt_left = pipe_ff[5'(rl - 5'h01)].bc4 ? 3'(`DDRC_BC4_CYC - 3'h1) :
                                              3'(`DDRC_BL8_CYC - 3'h1); // [R18]
    end else if (data_now) begin
      nxt_left = 3'(left_ff - 3'h1);
    end else begin
      nxt_left = 3'h0;
    end
    if (data_now) begin
      nxt_rs     = DDRC_RS_DATA;
      nxt_dq     = {elem_byte(c, e), elem_byte(c, 3'(e + 3'h1))}; // [R15]
      nxt_dq_oe  = 1'b1;
      nxt_dqs    = 2'h2; // [R16]
      nxt_dqs_oe = 1'b1;
    end else if (prep) begin
      nxt_rs     = DDRC_RS_PRE;
      nxt_dqs    = 2'h0; // [R16]
      nxt_dqs_oe = 1'b1;
    end else begin
      nxt_rs     = DDRC_RS_IDLE; // [R16]
    end
  end
  always_ff @(posedge ck_cmd or negedge crst_ff) begin
    if (!crst_ff) begin
      for (int i = 0; i < 4; i++) begin
        mr_ff[i] <= `DDRC_MR_RST;
      end
      for (int i = 0; i < 8; i++) begin
        bank_ff[i] <= '0;
      end
      for (int i = 0; i < `DDRC_PIPE_DEPTH; i++) begin
        pipe_ff[i] <= '0;
      end
      rs_ff      <= DDRC_RS_IDLE;
      left_ff    <= 3'h0;
      elem_ff    <= 3'h0;
      col_ff     <= 10'h000;
      cal_ff     <= 10'h000;
      mrs_tgl_ff <= 1'b0;
      open_ff    <= 8'h00;
      dq_o       <= 16'h0000;
      dq_oe      <= 1'b0;
      dqs_o      <= 2'h0;
      dqs_c_o    <= 2'h3;
      dqs_oe     <= 1'b0;
    end else begin
      mr_ff      <= nxt_mr;
      bank_ff    <= nxt_bank;
      pipe_ff    <= nxt_pipe;
      rs_ff      <= nxt_rs;
      left_ff    <= nxt_left;
      elem_ff    <= nxt_elem;
      col_ff     <= nxt_col;
      cal_ff     <= nxt_cal;
      mrs_tgl_ff <= nxt_mrs_tgl;
      open_ff    <= nxt_open;
      dq_o       <= nxt_dq;
      dq_oe      <= nxt_dq_oe;
      dqs_o      <= nxt_dqs;
      dqs_c_o    <= ~nxt_dqs;
      dqs_oe     <= nxt_dqs_oe;
    end
  end
  // crossing to ref_clk: levels through two flops, mrs event as a toggle
  logic [9:0] sy1_ff;
  logic [9:0] sy2_ff;
  logic [9:0] nxt_sy1;
  logic       tgl3_ff;
  logic [7:0] nxt_stat_open;
  logic       nxt_stat_cal;
  logic       nxt_stat_mrs;
  always_comb begin
    nxt_sy1       = {mrs_tgl_ff, (cal_ff != 10'h000), open_ff};
    nxt_stat_open = sy2_ff[7:0];
    nxt_stat_cal  = sy2_ff[8];
    nxt_stat_mrs  = sy2_ff[9] ^ tgl3_ff;
  end
  always_ff @(posedge ref_clk or negedge rrst_ff) begin
    if (!rrst_ff) begin
      sy1_ff          <= 10'h000;
      sy2_ff          <= 10'h000;
      tgl3_ff         <= 1'b0;
      stat_banks_open <= 8'h00;
      stat_cal_busy   <= 1'b0;
      stat_mrs_pulse  <= 1'b0;
    end else begin
      sy1_ff          <= nxt_sy1;
      sy2_ff          <= sy1_ff;
      tgl3_ff         <= sy2_ff[9];
      stat_banks_open <= nxt_stat_open;
      stat_cal_busy   <= nxt_stat_cal;
      stat_mrs_pulse  <= nxt_stat_mrs;
    end
  end
endmodule : ddrc_core

//--- ddrc_core_assertions.sv
// port checker for the dram command and read path
module ddrc_core_chk (
  // clocks and reset
  input wire logic                     ref_clk,
  input wire logic                     ck_cmd,
  input wire logic                     rst_n,
  // link side
  input wire ddrc_pkg::ddrc_cmd_pins_t cmd,
  input wire logic [15:0]              dq_o,
  input wire logic                     dq_oe,
  input wire logic [1:0]               dqs_o,
  input wire logic [1:0]               dqs_c_o,
  input wire logic                     dqs_oe,
  // status
  input wire logic                     stat_cal_busy,
  input wire logic                     stat_mrs_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  import ddrc_pkg::*;
  logic [31:0] rd_hist_ff;
  logic [31:0] nxt_rd_hist;
  logic        rd_now;
  // bit n set when a read was taken n clocks ago; a later read must not hide an earlier one
  always_comb begin
    rd_now      = !cmd.cs_n && ({cmd.ras_n, cmd.cas_n, cmd.we_n} == 3'b101);
    nxt_rd_hist = {rd_hist_ff[30:0], rd_now};
  end
  always_ff @(posedge ck_cmd or negedge rst_n) begin
    if (!rst_n) rd_hist_ff <= 32'h0000_0000;
    else rd_hist_ff <= nxt_rd_hist;
  end
  sequence s_pre;
    dqs_oe && !dq_oe && dqs_o == 2'b00;
  endsequence
  sequence s_data;
    dq_oe && dqs_oe && dqs_o == 2'b10;
  endsequence
  chk_pre_lead: assert property (@(posedge ck_cmd) disable iff (!rst_n)
    $rose(dqs_oe) |-> s_pre ##1 s_data) else $error("strobe without preamble");
  chk_data_strobe: assert property (@(posedge ck_cmd) disable iff (!rst_n)
    dq_oe |-> s_data) else $error("data without strobe");
  chk_strobe_pair: assert property (@(posedge ck_cmd) disable iff (!rst_n)
    dqs_oe |-> dqs_c_o == ~dqs_o) else $error("strobe halves not complementary");
  chk_end_release: assert property (@(posedge ck_cmd) disable iff (!rst_n)
    $fell(dq_oe) |-> !dqs_oe) else $error("strobe held after burst");
  chk_read_lat: assert property (@(posedge ck_cmd) disable iff (!rst_n)
    $rose(dq_oe) |-> (|rd_hist_ff[21:4])) else $error("data outside latency");
  chk_burst_whole: assert property (@(posedge ck_cmd) disable iff (!rst_n)
    $rose(dq_oe) |-> dq_oe [*2]) else $error("burst cut short");
  chk_elem_order: assert property (@(posedge ck_cmd) disable iff (!rst_n)
    dq_oe |-> dq_o[7:3] == dq_o[15:11] && dq_o[2:0] == dq_o[10:8] + 3'h1)
    else $error("falling element out of order");
  chk_cal_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(stat_cal_busy) |-> stat_cal_busy [*8]) else $error("calibration too short");
  chk_mrs_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stat_mrs_pulse |=> !stat_mrs_pulse) else $error("mode load pulse too long");
endmodule : ddrc_core_chk
bind ddrc_core ddrc_core_chk u_chk (.ref_clk(ref_clk), .ck_cmd(ck_cmd), .rst_n(rst_n),
  .cmd(cmd), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_c_o(dqs_c_o),
  .dqs_oe(dqs_oe), .stat_cal_busy(stat_cal_busy), .stat_mrs_pulse(stat_mrs_pulse));

//--- ddrc_ctrl_model.sv
// memory controller model driving the command pins
module ddrc_ctrl_model (
  // link
  input  wire logic                ck_cmd,
  output ddrc_pkg::ddrc_cmd_pins_t cmd,
  output logic [15:0]              dq_i,
  output logic [1:0]               dqs_i
);
  timeunit 1ns;
  timeprecision 100ps;
  import ddrc_pkg::*;
  initial cmd = {1'b1, 20'h0};
  initial dq_i = 16'h5a5a;
  initial dqs_i = 2'b01;
  // data bus kept off the device: lines toggle so nothing stale looks valid
  always @(posedge ck_cmd) begin
    dq_i <= ~dq_i;
    dqs_i <= ~dqs_i;
  end
  // caller sits just after a rise; gap counts clocks to the next command
  task automatic issue(input logic [2:0] op, input logic [2:0] ba,
                       input logic [13:0] a, input int gap);
    cmd = {1'b0, op, ba, a};
    @(posedge ck_cmd) #1;
    cmd = {1'b0, 3'b111, 3'h0, ~a};
    repeat (gap - 1) @(posedge ck_cmd);
    #1;
  endtask : issue
endmodule : ddrc_ctrl_model

//--- ddrc_defs.svh
// constants for the dram command and read path
`ifndef DDRC_DEFS_SVH
`define DDRC_DEFS_SVH
`define DDRC_CK_PS        80000
`define DDRC_T_RTP_PS     7500
`define DDRC_T_RAS_PS     35000
`define DDRC_NCK_RTP_MIN  4
`define DDRC_CYC(t)       (((t) + `DDRC_CK_PS - 1) / `DDRC_CK_PS)
`define DDRC_RTP_CYC      ((`DDRC_CYC(`DDRC_T_RTP_PS) > `DDRC_NCK_RTP_MIN) ? \
                           `DDRC_CYC(`DDRC_T_RTP_PS) : `DDRC_NCK_RTP_MIN)
`define DDRC_RAS_CYC      ((`DDRC_CYC(`DDRC_T_RAS_PS) > 1) ? `DDRC_CYC(`DDRC_T_RAS_PS) : 1)
`define DDRC_ZQCL_CYC     10'h200
`define DDRC_ZQCS_CYC     10'h040
`define DDRC_MR_RST       14'h0000
`define DDRC_MR0_BL_LSB   0
`define DDRC_MR0_CL_LSB   4
`define DDRC_MR1_AL_LSB   3
`define DDRC_CL_BASE      5'h04
`define DDRC_AP_BIT       10
`define DDRC_BC_BIT       12
`define DDRC_PIPE_DEPTH   32
`define DDRC_BL8_CYC      3'h4
`define DDRC_BC4_CYC      3'h2
`endif

//--- ddrc_pkg.sv
// types for the dram command and read path
package ddrc_pkg;
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [13:0] addr;
  } ddrc_cmd_pins_t;

  typedef enum logic [3:0] {
    DDRC_C_MRS = 4'h0,
    DDRC_C_REF = 4'h1,
    DDRC_C_PRE = 4'h2,
    DDRC_C_ACT = 4'h3,
    DDRC_C_WR  = 4'h4,
    DDRC_C_RD  = 4'h5,
    DDRC_C_ZQ  = 4'h6,
    DDRC_C_NOP = 4'h7,
    DDRC_C_DES = 4'h8
  } ddrc_cmd_t;

  typedef enum logic [1:0] {
    DDRC_RS_IDLE = 2'h0,
    DDRC_RS_PRE  = 2'h1,
    DDRC_RS_DATA = 2'h3
  } ddrc_rdst_t;

  typedef struct packed {
    logic       vld;
    logic       bc4;
    logic [9:0] col;
  } ddrc_rd_evt_t;

  typedef struct packed {
    logic       open;
    logic       ap_pend;
    logic [5:0] ap_cnt;
    logic [5:0] ras_cnt;
  } ddrc_bank_t;
endpackage : ddrc_pkg

//--- tb_ddrc_core.sv
// self-checking bench for the dram command and read path
module tb_ddrc_core;
  timeunit 1ns;
  timeprecision 100ps;
  import ddrc_pkg::*;
  logic ref_clk = 1'b0, ck_cmd = 1'b0, rst_n = 1'b0;
  ddrc_cmd_pins_t cmd;
  logic [15:0] dq_i, dq_o;
  logic [1:0] dqs_i, dqs_o, dqs_c_o;
  logic dq_oe, dqs_oe, stat_cal_busy, stat_mrs_pulse;
  logic [7:0] stat_banks_open;
  logic [13:0] mr0 = '0, mr1 = '0;
  int err_total = 0, cmp_count = 0, cyc = 0, mrs_seen = 0, mrs_exp = 0;
  int exp_cyc[$];
  logic [15:0] exp_dq[$];
  always #10 ref_clk = ~ref_clk;
  always begin
    #7;
    forever #40 ck_cmd = ~ck_cmd;
  end
  ddrc_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .ck_cmd(ck_cmd), .cmd(cmd), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe(dq_oe), .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_c_o(dqs_c_o),
    .dqs_oe(dqs_oe), .stat_banks_open(stat_banks_open), .stat_cal_busy(stat_cal_busy),
    .stat_mrs_pulse(stat_mrs_pulse));
  ddrc_ctrl_model m (.ck_cmd(ck_cmd), .cmd(cmd), .dq_i(dq_i), .dqs_i(dqs_i));
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp=%h got=%h", what, exp, got);
    end
  endtask : chk
  task automatic finish_test;
    $display("compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // read: note every data cycle with the clock it must appear on
  task automatic rd(input logic [2:0] ba, input logic [9:0] col, input logic ap,
                    input logic a12, input int gap);
    int cl, al, n;
    cl = 4 + mr0[6:4];
    al = (mr1[4:3] == 2'b01) ? cl - 1 : (mr1[4:3] == 2'b10) ? cl - 2 : 0;
    n = (mr0[1:0] == 2'b10 || (mr0[1:0] == 2'b01 && !a12)) ? 2 : 4;
    for (int j = 0; j < n; j++) begin
      exp_cyc.push_back(cyc + 1 + al + cl + j);
      exp_dq.push_back({col[7:3], col[2:0] + 3'(2 * j), col[7:3], col[2:0] + 3'(2 * j + 1)});
    end
    m.issue(3'b101, ba, {1'b0, a12, 1'b0, ap, col}, gap);
  endtask : rd
  task automatic mrs(input logic [2:0] ba, input logic [13:0] v);
    if (ba == 3'h0) mr0 = v;
    if (ba == 3'h1) mr1 = v;
    if (!ba[2]) mrs_exp++;
    m.issue(3'b000, ba, v, 8);
  endtask : mrs
  always @(posedge ck_cmd) cyc++;
  always @(posedge ref_clk) if (stat_mrs_pulse === 1'b1) mrs_seen++;
  always @(negedge ck_cmd) begin
    if (dq_oe === 1'b1 && exp_dq.size() > 0) begin
      chk("dq", dq_o, exp_dq.pop_front());
      chk("when", 16'(cyc), 16'(exp_cyc.pop_front()));
    end else if (dqs_oe === 1'b1) chk("pre", dqs_o, 2'b00);
    else chk("hiz", dq_oe, 1'b0);
  end
  initial begin
    #200us;
    err_total++;
    finish_test();
  end
  initial begin
    void'($urandom(98851));
    repeat (4) @(posedge ck_cmd);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge ck_cmd);
    #1 m.issue(3'b011, 3'h0, 14'h0, 4);
    repeat (3) rd(3'h0, 10'($urandom), 1'b0, 1'b1, 4);
    for (int k = 0; k < 4; k++) begin
      m.issue(3'b010, 3'h0, 14'h0400, 12);
      mrs(3'h0, {7'h0, 3'(k), 2'b00, 2'(k)});
      mrs(3'h1, {9'h0, 2'(k), 3'h0});
      m.issue(3'b011, 3'(k), 14'h0, 2);
      rd(3'(k), 10'($urandom), 1'b0, 1'($urandom), 4);
      rd(3'(k), 10'($urandom), 1'b0, 1'($urandom), 30);
    end
    m.issue(3'b010, 3'h0, 14'h0400, 12);
    mrs(3'h4, 14'h3fff);
    mrs(3'h0, 14'h0);
    mrs(3'h1, 14'h0);
    mrs(3'h3, 14'h0);
    m.issue(3'b011, 3'h5, 14'h0, 4);
    m.issue(3'b011, 3'h6, 14'h0, 8);
    chk("open5", stat_banks_open[5], 1'b1);
    rd(3'h5, 10'h0, 1'b1, 1'b1, 4);
    rd(3'h6, 10'h9, 1'b0, 1'b1, 20);
    chk("ap5", stat_banks_open[5], 1'b0);
    chk("open6", stat_banks_open[6], 1'b1);
    m.issue(3'b010, 3'h6, 14'h0000, 12);
    chk("pre6", stat_banks_open[6], 1'b0);
    m.issue(3'b010, 3'h0, 14'h0400, 12);
    chk("allpre", stat_banks_open, 8'h0);
    m.issue(3'b110, 3'h0, 14'h0400, 508);
    chk("zql", stat_cal_busy, 1'b1);
    m.issue(3'b111, 3'h0, 14'h0, 8);
    chk("zqlend", stat_cal_busy, 1'b0);
    m.issue(3'b110, 3'h0, 14'h0, 62);
    chk("zqs", stat_cal_busy, 1'b1);
    m.issue(3'b111, 3'h0, 14'h0, 6);
    chk("zqsend", stat_cal_busy, 1'b0);
    chk("mrs", 16'(mrs_seen), 16'(mrs_exp));
    chk("left", 16'(exp_dq.size()), 16'h0);
    finish_test();
  end
endmodule : tb_ddrc_core
